// *** src/expander_defs.vh ***
// Constants for the two-wire eight-bit output expander
`ifndef EXPANDER_DEFS_VH
`define EXPANDER_DEFS_VH

// ============================================================
// Timing
`define CLK_PERIOD_NS 10
`define SPIKE_NS 50
// A level must outlast every sample a spike could cover, plus one
`define FILTER_CYCLES (`SPIKE_NS / `CLK_PERIOD_NS + 1)
`define POWERUP_WAIT 4'h8

// ============================================================
// Slave address: fixed upper bits, then two bits per address pin
`define ADDR_PREFIX 3'h5
`define ADDR_PREFIX_POS 4

// ============================================================
// Four-level address pin codes
`define LVL_GND 2'h0
`define LVL_VPLUS 2'h1
`define LVL_SCL 2'h2
`define LVL_SDA 2'h3

// ============================================================
// Output reset values
`define NIBBLE_LOW 4'h0
`define NIBBLE_HIGH 4'hF

`endif

// *** src/i2c_output_expander.v ***
// Two-wire slave driving an eight-bit push-pull output port
// What this block does, and what it needs of the master
// R1 - Answers as a slave at one of sixteen addresses 0x50 to 0x5F picked by the two select pins.
// R2 - Each select pin is read as one of four states: ground, supply, tied to clock, tied to data.
// R3 - A low reset pin abandons any transfer and returns the bus logic to idle.
// R4 - The master waits at least 1 us after reset pin release before a start.
// R5 - Eight output bits 0 to 7 are driven push-pull at all times.
// R6 - Clock and data glitches narrower than 50 ns are ignored.
// R7 - The bus runs correctly at clock rates up to 400 kHz and the master stays within that.
// R8 - After power-up the outputs take a default picked by the select pins with no transfer.
// R9 - Each acknowledged written byte sets all eight outputs at once, bit 7 to output 7.
// R10 - A read returns the present output levels most significant bit first.
`timescale 1ns/1ns
`default_nettype none
`include "expander_defs.vh"

module i2c_output_expander #(
	parameter WIDTH = 8
) (
	input wire clk,
	input wire reset,
	input wire scl,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	input wire reset_n_pin,
	input wire address_select_low,
	input wire address_select_high,
	output reg [WIDTH-1:0] push_pull_outputs
);

	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_ADDR = 3'h1;
	localparam [2:0] ST_ACK_ADDR = 3'h2;
	localparam [2:0] ST_WRITE = 3'h3;
	localparam [2:0] ST_ACK_DATA = 3'h4;
	localparam [2:0] ST_READ = 3'h5;
	localparam [2:0] ST_READ_ACK = 3'h6;
	localparam integer FILTER_INT = `FILTER_CYCLES;
	localparam [2:0] FILTER_LEN = FILTER_INT[2:0];

	// Default nibble: ground gives low, anything else high
	function [3:0] default_nibble;
		input [1:0] code;
		begin
			default_nibble = (code == `LVL_GND) ? `NIBBLE_LOW : `NIBBLE_HIGH;
		end
	endfunction

	// ============================================================
	// Input synchronisers
	reg [4:0] sync1;
	reg [4:0] sync2;
	always @(posedge clk) begin
		if (reset) begin
			sync1 <= 5'h1F;
			sync2 <= 5'h1F;
		end else begin
			sync1 <= {address_select_high, address_select_low, reset_n_pin, sda_in, scl};
			sync2 <= sync1;
		end
	end

	wire pin_rst_n = sync2[2];
	wire pin_low = sync2[3];
	wire pin_high = sync2[4];

	// ============================================================
	// Spike filter on clock and data
	reg [1:0] line;
	reg [2:0] flt_cnt [0:1];
	integer i;
	always @(posedge clk) begin
		for (i = 0; i < 2; i = i + 1) begin
			if (reset) begin
				line[i] <= 1'b1;
				flt_cnt[i] <= 3'h0;
			end else if (sync2[i] == line[i]) begin
				flt_cnt[i] <= 3'h0;
			end else if (flt_cnt[i] == FILTER_LEN - 3'h1) begin
				line[i] <= sync2[i]; // R6
				flt_cnt[i] <= 3'h0;
			end else begin
				flt_cnt[i] <= flt_cnt[i] + 3'h1;
			end
		end
	end

	reg [1:0] line_d;
	always @(posedge clk) begin
		if (reset) begin
			line_d <= 2'h3;
		end else begin
			line_d <= line;
		end
	end

	wire scl_rise = line[0] & ~line_d[0];
	wire scl_fall = ~line[0] & line_d[0];
	wire start_ev = line[0] & line_d[0] & ~line[1] & line_d[1];
	wire stop_ev = line[0] & line_d[0] & line[1] & ~line_d[1];

	// ============================================================
	// Slave state machine
	reg [2:0] state;
	reg [3:0] bit_cnt;
	reg [7:0] shift;
	reg rw;
	reg [1:0] code_low;
	reg [1:0] code_high;
	reg idle_low;
	reg idle_high;
	reg [3:0] pu_cnt;
	reg pu_done;
	wire [6:0] own_addr = {`ADDR_PREFIX, ~code_high[1], code_high[0], code_low};

	always @(posedge clk) begin
		if (reset) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			rw <= 1'b0;
			code_low <= `LVL_VPLUS;
			code_high <= `LVL_VPLUS;
			idle_low <= 1'b1;
			idle_high <= 1'b1;
			pu_cnt <= 4'h0;
			pu_done <= 1'b0;
			sda_out <= 1'b0;
			sda_oe_n <= 1'b1;
			push_pull_outputs <= {WIDTH{1'b1}}; // R5
		end else begin
			// Pins are caught only after the synchronisers have settled
			if (!pu_done) begin
				if (pu_cnt == `POWERUP_WAIT) begin
					pu_done <= 1'b1;
					push_pull_outputs <= {default_nibble(pin_high ? `LVL_VPLUS : `LVL_GND),
						default_nibble(pin_low ? `LVL_VPLUS : `LVL_GND)}; // R8
				end else begin
					pu_cnt <= pu_cnt + 4'h1;
				end
			end
			// Raw lines too, else a data-tied pin is caught low inside the filter delay of a start
			if (state == ST_IDLE && line == 2'h3 && sync2[1:0] == 2'h3) begin
				idle_low <= pin_low;
				idle_high <= pin_high;
			end
			if (!pin_rst_n) begin
				state <= ST_IDLE; // R3
				sda_oe_n <= 1'b1;
			end else if (stop_ev) begin
				state <= ST_IDLE;
				sda_oe_n <= 1'b1;
			end else if (start_ev) begin
				// Ground reads low at idle, data-tied pin follows the start low
				code_low <= !idle_low ? `LVL_GND : (!pin_low ? `LVL_SDA : `LVL_VPLUS); // R2
				code_high <= !idle_high ? `LVL_GND : (!pin_high ? `LVL_SDA : `LVL_VPLUS);
				state <= ST_ADDR;
				bit_cnt <= 4'h0;
				sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				case (state)
					ST_ADDR, ST_WRITE: begin
						shift <= {shift[6:0], line[1]}; // R7
						bit_cnt <= bit_cnt + 4'h1;
					end
					ST_READ: begin
						bit_cnt <= bit_cnt + 4'h1;
					end
					ST_READ_ACK: begin
						if (!line[1]) begin
							shift <= push_pull_outputs;
							bit_cnt <= 4'h0;
							state <= ST_READ;
						end else begin
							state <= ST_IDLE;
						end
					end
					default: begin
					end
				endcase
			end else if (scl_fall) begin
				case (state)
					ST_ADDR: begin
						// Clock-tied pin is high at start and low at the first fall
						if (bit_cnt == 4'h0) begin
							if (code_low == `LVL_VPLUS && !pin_low) begin
								code_low <= `LVL_SCL; // R2
							end
							if (code_high == `LVL_VPLUS && !pin_high) begin
								code_high <= `LVL_SCL;
							end
						end
						if (bit_cnt == 4'h8) begin
							if (shift[7:1] == own_addr) begin
								rw <= shift[0]; // R1
								sda_oe_n <= 1'b0;
								state <= ST_ACK_ADDR;
							end else begin
								state <= ST_IDLE;
							end
						end
					end
					ST_ACK_ADDR: begin
						bit_cnt <= 4'h0;
						if (rw) begin
							sda_oe_n <= push_pull_outputs[7]; // R10
							shift <= {push_pull_outputs[6:0], 1'b0};
							state <= ST_READ;
						end else begin
							sda_oe_n <= 1'b1;
							state <= ST_WRITE;
						end
					end
					ST_WRITE: begin
						if (bit_cnt == 4'h8) begin
							sda_oe_n <= 1'b0;
							state <= ST_ACK_DATA;
						end
					end
					ST_ACK_DATA: begin
						// Byte lands only once its acknowledge has been clocked
						push_pull_outputs <= shift; // R9
						sda_oe_n <= 1'b1;
						bit_cnt <= 4'h0;
						state <= ST_WRITE;
					end
					ST_READ: begin
						if (bit_cnt == 4'h8) begin
							sda_oe_n <= 1'b1;
							state <= ST_READ_ACK;
						end else begin
							sda_oe_n <= shift[7]; // R10
							shift <= {shift[6:0], 1'b0};
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

endmodule

`default_nettype wire

// *** verification/expander_checker_sva.sv ***
// Pin assertions for the output expander
`timescale 1ns/1ns
`default_nettype none
module expander_checker (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic reset_n_pin,
	input wire logic [7:0] push_pull_outputs
);
	// ====
	// Properties
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	property p_rst; disable iff (1'h0) reset |=> push_pull_outputs == 8'hFF && sda_oe_n; endproperty
	a_rst: assert property (p_rst) else $error("reset state");
	property p_pin; !reset_n_pin [*6] |-> sda_oe_n; endproperty
	a_pin: assert property (p_pin) else $error("pin reset");
	property p_keep; !reset_n_pin |=> $stable(push_pull_outputs); endproperty
	a_keep: assert property (p_keep) else $error("pin reset output");
	// Power-up load lands with the bus idle, so skip the first cycles after reset
	property p_upd; $changed(push_pull_outputs) && !$past(reset, 12) |-> !scl; endproperty
	a_upd: assert property (p_upd) else $error("update");
	property p_ack; $fell(sda_oe_n) |-> !scl; endproperty
	a_ack: assert property (p_ack) else $error("drive");
	property p_rel; $rose(sda_oe_n) |-> !scl || !reset_n_pin; endproperty
	a_rel: assert property (p_rel) else $error("release");
	property p_od; !sda_out; endproperty
	a_od: assert property (p_od) else $error("sda level");
	property p_hold; $rose(scl) && reset_n_pin |=> $stable(sda_oe_n) [*3]; endproperty
	a_hold: assert property (p_hold) else $error("spike");
	c_ack: cover property ($fell(sda_oe_n));
	c_upd: cover property ($changed(push_pull_outputs) && !scl);
	c_pin: cover property (!reset_n_pin [*6]);
endmodule
`default_nettype wire

// *** verification/i2c_bus_master.sv ***
// Two-wire bus master model
`timescale 1ns/1ns
`default_nettype none
module i2c_bus_master (
	output logic scl,
	output logic sda_m,
	input wire logic sda
);
	// ====
	// 1300 ns low, 1200 ns high keeps 400 kHz; g adds a 30 ns clock spike
	logic g = 1'h0;
	initial {scl, sda_m} = 2'h3;
	task automatic bit_io(input logic b, output logic r);
		#300 sda_m <= b;
		#400 scl <= g;
		#30 scl <= 1'h0;
		#570 scl <= 1'h1;
		#600 r = sda;
		#600 scl <= 1'h0;
	endtask
	task automatic xfer(input [7:0] d, output logic [7:0] q, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q = {q[6:0], r};
		end
		bit_io(1'h1, a);
	endtask
	task automatic xact(input [7:0] h, input [7:0] d, output logic a, output logic [7:0] q);
		#600 scl <= 1'h1;
		#600 sda_m <= 1'h0;
		#600 scl <= 1'h0;
		xfer(h, q, a);
		if (a === 1'h0) xfer(d, q, a);
		#300 sda_m <= 1'h0;
		#1000 scl <= 1'h1;
		#600 sda_m <= 1'h1;
		#1300;
	endtask
endmodule
`default_nettype wire

// *** verification/i2c_eight_bit_output_expander_tb.sv ***
// Self-checking bench for the output expander
`timescale 1ns/1ns
`default_nettype none
module i2c_eight_bit_output_expander_tb;
	// ====
	// Wiring: released SDA is pulled high
	logic clk = 1'h0, reset = 1'h1, reset_n_pin = 1'h1, ack;
	logic [1:0] sel_lo = 2'h0, sel_hi = 2'h0;
	logic [6:0] adr;
	logic [7:0] d, q;
	int fails = 0, checks = 0;
	wire scl, sda_m, sda_out, sda_oe_n;
	wire [7:0] outs;
	wire sda = sda_m & (sda_oe_n | sda_out);
	// Select pins tie to ground, supply, bus clock or bus data
	wire lo = sel_lo[1] ? (sel_lo[0] ? sda : scl) : sel_lo[0];
	wire hi = sel_hi[1] ? (sel_hi[0] ? sda : scl) : sel_hi[0];
	always #5 clk = ~clk;
	i2c_output_expander i2c_output_expander_i (.clk(clk), .reset(reset), .scl(scl), .sda_in(sda),
		.sda_out(sda_out), .sda_oe_n(sda_oe_n), .reset_n_pin(reset_n_pin),
		.address_select_low(lo), .address_select_high(hi), .push_pull_outputs(outs));
	i2c_bus_master bus (.scl(scl), .sda_m(sda_m), .sda(sda));
	function automatic logic [6:0] addr_of(input logic [1:0] l, input logic [1:0] h);
		logic [1:0] hb;
		case (h)
			2'h0: hb = 2'h2;
			2'h1: hb = 2'h3;
			2'h2: hb = 2'h0;
			default: hb = 2'h1;
		endcase
		return {3'h5, hb, l};
	endfunction
	function automatic logic [7:0] dflt_of(input logic [1:0] l, input logic [1:0] h);
		return {(h == 2'h0) ? 4'h0 : 4'hF, (l == 2'h0) ? 4'h0 : 4'hF};
	endfunction
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			fails++;
			$display("FAIL %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic test_done;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ====
	// Scenarios
	initial begin
		void'($urandom(32'h50A20FCA));
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			{sel_hi, sel_lo} <= {2'(k + 1), 2'(k)};
			reset <= 1'h1;
			repeat (20) @(posedge clk);
			reset <= 1'h0;
			repeat (30) @(posedge clk);
			adr = addr_of(sel_lo, sel_hi);
			chk("default", dflt_of(sel_lo, sel_hi), outs);
			d = 8'($urandom);
			bus.g = k[0];
			bus.xact({adr ^ 7'h04, 1'h0}, d, ack, q);
			chk("foreign", 8'h01, {7'h00, ack});
			bus.xact({adr, 1'h0}, d, ack, q);
			chk("written", d, outs);
			bus.xact({adr, 1'h1}, 8'hFF, ack, q);
			chk("read", d, q);
		end
		// Pin reset lands just after the address was acknowledged
		fork
			bus.xact({adr, 1'h0}, ~d, ack, q);
			begin
				repeat (2440) @(posedge clk);
				reset_n_pin <= 1'h0;
				repeat (60) @(posedge clk);
				reset_n_pin <= 1'h1;
			end
		join
		chk("abandoned", d, outs);
		bus.xact({adr, 1'h0}, ~d, ack, q);
		chk("recovered", ~d, outs);
		test_done;
	end
endmodule
bind i2c_output_expander expander_checker expander_checker_i (.clk(clk), .reset(reset),
	.scl(scl), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .reset_n_pin(reset_n_pin),
	.push_pull_outputs(push_pull_outputs));
`default_nettype wire
